// file: hdl/vit_map.svh
// Constants for the init block checker and bus tenure arbiter
//
// Overview of operation
// - Memory type bits 9:8 must be 3, Short I/O; other codes rejected.
// - Buffer address is the init block offset; device reads from there.
// - Transfer length is block size; a wrong length drops the parameters.
// - Burst word bit 15 picks burst count or time on/off mode.
// - Burst count zero keeps the bus until no data remains.
// - Counts 1..32 release on done, 16 us, or another request.
// - Counts 33..64 release on done or 16 us; requests ignored.
// - Counts 65..128 release on done or 32 us.
// - Counts 129..255 release on done or 64 us.
// - Time on code 0..6 gives 16 to 1024 us; 7 holds until done.
// - Time off code 0 no wait; 1..7 gives 16 to 1024 us.
// - Fair bit, time on/off mode only: wait for request line negated before requesting.
// - Normal completion uses vector 7:0 and level 10:8 unmodified.
// - Error completion uses vector 7:0 and level 10:8.
// - Error level zero raises no interrupt but still records the error.
`ifndef VIT_MAP_SVH
`define VIT_MAP_SVH
// ****************************************
// Register offsets
// ****************************************
`define VIT_OFS_CTRL 12'h000
`define VIT_OFS_XFER 12'h004
`define VIT_OFS_BUFADDR 12'h008
`define VIT_OFS_MAXLEN 12'h00c
`define VIT_OFS_SLOTS 12'h010
`define VIT_OFS_BURST 12'h014
`define VIT_OFS_NORM 12'h018
`define VIT_OFS_ERR 12'h01c
`define VIT_OFS_STATUS 12'h020
`define VIT_OFS_EVENT 12'h024
// ****************************************
// Field positions
// ****************************************
`define VIT_MEMTYPE_LO 8
`define VIT_MEMTYPE_SHORTIO 2'h3
`define VIT_BURST_MODE_BIT 15
`define VIT_BURST_FAIR_BIT 14
`define VIT_TON_LO 0
`define VIT_TOFF_LO 4
`define VIT_LEVEL_LO 8
`define VIT_CTRL_GO_BIT 0
`define VIT_CTRL_PEND_BIT 1
`define VIT_EV_NORM_BIT 0
`define VIT_EV_ERR_BIT 1
// ****************************************
// Reset values and timing
// ****************************************
`define VIT_BLOCK_BYTES 32'h0000_0030
`define VIT_RST_WORD 32'h0000_0000
`define VIT_CLK_MHZ 125
`define VIT_BASE_US 16
`define VIT_BASE_CYC (`VIT_BASE_US * `VIT_CLK_MHZ)
`endif

// file: hdl/vit_pkg.sv
// Types for the init block checker and bus tenure arbiter
package vit_pkg;
  typedef enum logic [3:0] {
    VIT_IDLE = 4'b0001,
    VIT_REQ = 4'b0010,
    VIT_HOLD = 4'b0100,
    VIT_OFF = 4'b1000
  } vit_state_e;
  typedef struct packed {
    logic mode_fair_tt;
    logic fair;
    logic [7:0] count;
    logic [2:0] ton;
    logic [2:0] toff;
  } vit_burst_s;
  typedef struct packed {
    logic req;
    logic [2:0] level;
    logic [7:0] vector;
  } vit_irq_s;
endpackage : vit_pkg

// file: hdl/vit_timer.sv
// Tenure and off-time cycle counter
`timescale 1ns/1ps
module vit_timer #(
  parameter int unsigned BASE_CYC = 2000,
  parameter int unsigned WIDTH = 20
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic start,
  input wire logic run,
  input wire logic [2:0] shift,
  // Result
  output logic expired
);
  logic [WIDTH-1:0] cnt_reg;
  logic [WIDTH-1:0] limit;
  assign limit = WIDTH'(BASE_CYC << shift) - WIDTH'(1);
  always_ff @(posedge clk) begin
    if (rst || start || !run) begin
      cnt_reg <= '0;
    end else if (cnt_reg != limit) begin
      cnt_reg <= cnt_reg + WIDTH'(1);
    end
  end
  // Expires the cycle the count reaches the limit
  assign expired = run && !start && (cnt_reg == limit);
endmodule : vit_timer

// file: hdl/vit_arbiter.sv
// Init command checker and bus tenure arbiter with AHB-Lite registers
`timescale 1ns/1ps
`include "vit_map.svh"
module vit_arbiter #(
  parameter int unsigned BASE_CYC = `VIT_BASE_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Bus arbitration
  input wire logic bus_grant,
  input wire logic bus_req_line,
  output logic bus_req,
  output logic bus_busy,
  // Completion
  input wire logic done_ok,
  input wire logic done_err,
  output logic init_accepted,
  output logic [31:0] block_offset,
  output vit_pkg::vit_irq_s irq_out,
  output logic err_recorded
);
  // ****************************************
  // Register file
  // ****************************************
  logic [31:0] xfer_reg, bufaddr_reg, maxlen_reg, slots_reg, burst_reg;
  logic [15:0] norm_reg, err_reg;
  logic pend_reg, accepted_reg, rejected_reg;
  logic [1:0] event_reg;
  logic wr_pend_reg;
  logic [11:0] wr_addr_reg;
  logic go_pulse, init_ok;
  vit_pkg::vit_burst_s cfg;
  vit_pkg::vit_state_e state_reg;

  // Address phase capture; zero wait states
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 12'h000;
    end else if (hready) begin
      wr_pend_reg <= hsel && htrans[1] && hwrite && hsize == 3'h2;
      wr_addr_reg <= haddr;
    end
  end

  assign go_pulse = wr_pend_reg && wr_addr_reg == `VIT_OFS_CTRL && hwdata[`VIT_CTRL_GO_BIT];
  // Only memory type 3 with a matching block size is taken
  assign init_ok = xfer_reg[`VIT_MEMTYPE_LO+:2] == `VIT_MEMTYPE_SHORTIO
    && maxlen_reg == `VIT_BLOCK_BYTES;

  always_ff @(posedge clk) begin
    if (rst) begin
      xfer_reg <= `VIT_RST_WORD;
      bufaddr_reg <= `VIT_RST_WORD;
      maxlen_reg <= `VIT_RST_WORD;
      slots_reg <= `VIT_RST_WORD;
      burst_reg <= `VIT_RST_WORD;
      norm_reg <= 16'h0000;
      err_reg <= 16'h0000;
    end else if (wr_pend_reg && !accepted_reg) begin
      // Parameters freeze once accepted; host must not touch them meanwhile
      case (wr_addr_reg)
        `VIT_OFS_XFER: xfer_reg <= hwdata;
        `VIT_OFS_BUFADDR: bufaddr_reg <= hwdata;
        `VIT_OFS_MAXLEN: maxlen_reg <= hwdata;
        `VIT_OFS_SLOTS: slots_reg <= hwdata;
        `VIT_OFS_BURST: burst_reg <= hwdata;
        `VIT_OFS_NORM: norm_reg <= hwdata[15:0];
        `VIT_OFS_ERR: err_reg <= hwdata[15:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      accepted_reg <= 1'b0;
      rejected_reg <= 1'b0;
      block_offset <= 32'h0000_0000;
      init_accepted <= 1'b0;
    end else if (go_pulse) begin
      accepted_reg <= init_ok;
      rejected_reg <= !init_ok;
      init_accepted <= init_ok;
      if (init_ok) begin
        block_offset <= bufaddr_reg;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pend_reg <= 1'b0;
    end else if (wr_pend_reg && wr_addr_reg == `VIT_OFS_CTRL) begin
      pend_reg <= hwdata[`VIT_CTRL_PEND_BIT];
    end
  end

  // Sticky completion events; set wins over a write-one clear
  always_ff @(posedge clk) begin
    if (rst) begin
      event_reg <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == 0 && done_ok) || (i == 1 && done_err)) begin
          event_reg[i] <= 1'b1;
        end else if (wr_pend_reg && wr_addr_reg == `VIT_OFS_EVENT && hwdata[i]) begin
          event_reg[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite && hsize == 3'h2) begin
      case (haddr)
        `VIT_OFS_CTRL: hrdata <= {30'h0, pend_reg, 1'b0};
        `VIT_OFS_XFER: hrdata <= xfer_reg;
        `VIT_OFS_BUFADDR: hrdata <= bufaddr_reg;
        `VIT_OFS_MAXLEN: hrdata <= maxlen_reg;
        `VIT_OFS_SLOTS: hrdata <= slots_reg;
        `VIT_OFS_BURST: hrdata <= burst_reg;
        `VIT_OFS_NORM: hrdata <= {16'h0, norm_reg};
        `VIT_OFS_ERR: hrdata <= {16'h0, err_reg};
        `VIT_OFS_STATUS: hrdata <= {24'h0, state_reg, bus_busy, bus_req, rejected_reg,
          accepted_reg};
        `VIT_OFS_EVENT: hrdata <= {30'h0, event_reg};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ****************************************
  // Burst configuration decode
  // ****************************************
  assign cfg.mode_fair_tt = burst_reg[`VIT_BURST_MODE_BIT];
  assign cfg.fair = burst_reg[`VIT_BURST_FAIR_BIT];
  assign cfg.count = burst_reg[7:0];
  assign cfg.ton = burst_reg[`VIT_TON_LO+:3];
  assign cfg.toff = burst_reg[`VIT_TOFF_LO+:3];

  logic hold_forever, yield_on_req;
  logic [2:0] on_shift;
  always_comb begin
    hold_forever = 1'b0;
    yield_on_req = 1'b0;
    on_shift = 3'd0;
    if (cfg.mode_fair_tt) begin
      hold_forever = cfg.ton == 3'd7;
      on_shift = cfg.ton;
    end else if (cfg.count == 8'h00) begin
      hold_forever = 1'b1;
    end else if (cfg.count <= 8'h20) begin
      yield_on_req = 1'b1;
    end else if (cfg.count <= 8'h40) begin
      on_shift = 3'd0;
    end else if (cfg.count <= 8'h80) begin
      on_shift = 3'd1;
    end else begin
      on_shift = 3'd2;
    end
  end

  // ****************************************
  // Tenure state machine
  // ****************************************
  logic on_exp, off_exp, want, release_now, fair_block;
  logic [2:0] off_shift;
  assign want = accepted_reg && pend_reg;
  assign off_shift = cfg.toff - 3'd1;
  assign fair_block = cfg.mode_fair_tt && cfg.fair && bus_req_line && !bus_req;
  assign release_now = !pend_reg || (!hold_forever && on_exp)
    || (yield_on_req && bus_req_line);

  vit_timer #(.BASE_CYC(BASE_CYC), .WIDTH(20)) u_on (
    .clk(clk),
    .rst(rst),
    .start(state_reg == vit_pkg::VIT_REQ && bus_grant),
    .run(state_reg == vit_pkg::VIT_HOLD),
    .shift(on_shift),
    .expired(on_exp)
  );
  vit_timer #(.BASE_CYC(BASE_CYC), .WIDTH(20)) u_off (
    .clk(clk),
    .rst(rst),
    .start(state_reg == vit_pkg::VIT_HOLD && release_now),
    .run(state_reg == vit_pkg::VIT_OFF),
    .shift(off_shift),
    .expired(off_exp)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= vit_pkg::VIT_IDLE;
      bus_req <= 1'b0;
      bus_busy <= 1'b0;
    end else begin
      case (state_reg)
        vit_pkg::VIT_IDLE: begin
          if (want && !fair_block) begin
            state_reg <= vit_pkg::VIT_REQ;
            bus_req <= 1'b1;
          end
        end
        vit_pkg::VIT_REQ: begin
          if (bus_grant) begin
            state_reg <= vit_pkg::VIT_HOLD;
            bus_req <= 1'b0;
            bus_busy <= 1'b1;
          end
        end
        vit_pkg::VIT_HOLD: begin
          if (release_now) begin
            bus_busy <= 1'b0;
            if (cfg.mode_fair_tt && cfg.toff != 3'd0) begin
              state_reg <= vit_pkg::VIT_OFF;
            end else begin
              state_reg <= vit_pkg::VIT_IDLE;
            end
          end
        end
        vit_pkg::VIT_OFF: begin
          if (off_exp) begin
            state_reg <= vit_pkg::VIT_IDLE;
          end
        end
        default: begin
          state_reg <= vit_pkg::VIT_IDLE;
          bus_req <= 1'b0;
          bus_busy <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // Completion interrupt selection
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_out <= '0;
      err_recorded <= 1'b0;
    end else begin
      err_recorded <= done_err;
      if (done_err) begin
        irq_out.vector <= err_reg[7:0];
        irq_out.level <= err_reg[`VIT_LEVEL_LO+:3];
        irq_out.req <= err_reg[`VIT_LEVEL_LO+:3] != 3'd0;
      end else if (done_ok) begin
        irq_out.vector <= norm_reg[7:0];
        irq_out.level <= norm_reg[`VIT_LEVEL_LO+:3];
        irq_out.req <= 1'b1;
      end else begin
        irq_out.req <= 1'b0;
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  property p_reject_bad_mem;
    @(posedge clk) disable iff (rst)
      go_pulse && xfer_reg[9:8] != 2'h3 |=> !accepted_reg && rejected_reg;
  endproperty
  a_reject_bad_mem: assert property (p_reject_bad_mem) else $error("bad memory type taken");
  property p_len_check;
    @(posedge clk) disable iff (rst)
      go_pulse && maxlen_reg != `VIT_BLOCK_BYTES |=> !init_accepted;
  endproperty
  a_len_check: assert property (p_len_check) else $error("wrong length accepted");
  property p_offset;
    @(posedge clk) disable iff (rst) go_pulse && init_ok |=> block_offset == $past(bufaddr_reg);
  endproperty
  a_offset: assert property (p_offset) else $error("offset not captured");
  property p_grant_hold;
    @(posedge clk) disable iff (rst)
      state_reg == vit_pkg::VIT_REQ && bus_grant |=> bus_busy && !bus_req;
  endproperty
  a_grant_hold: assert property (p_grant_hold) else $error("grant not taken");
  property p_yield;
    @(posedge clk) disable iff (rst)
      bus_busy && !cfg.mode_fair_tt && cfg.count - 8'h01 < 8'h20 && bus_req_line |=> !bus_busy;
  endproperty
  a_yield: assert property (p_yield) else $error("no yield on request");
  property p_no_yield;
    @(posedge clk) disable iff (rst)
      bus_busy && !cfg.mode_fair_tt && cfg.count == 8'h00 && pend_reg |=> bus_busy;
  endproperty
  a_no_yield: assert property (p_no_yield) else $error("count zero released early");
  property p_fair;
    @(posedge clk) disable iff (rst)
      state_reg == vit_pkg::VIT_IDLE && cfg.mode_fair_tt && cfg.fair && bus_req_line
      |=> !bus_req;
  endproperty
  a_fair: assert property (p_fair) else $error("fair check ignored");
  property p_err_level0;
    @(posedge clk) disable iff (rst)
      done_err && err_reg[10:8] == 3'd0 |=> !irq_out.req && err_recorded;
  endproperty
  a_err_level0: assert property (p_err_level0) else $error("level zero raised irq");
  property p_norm_vec;
    @(posedge clk) disable iff (rst)
      done_ok && !done_err |=> irq_out.req && irq_out.vector == $past(norm_reg[7:0]);
  endproperty
  a_norm_vec: assert property (p_norm_vec) else $error("normal vector wrong");
  c_grant: cover property (@(posedge clk) disable iff (rst) bus_busy ##1 !bus_busy);
  c_off: cover property (@(posedge clk) disable iff (rst) state_reg == vit_pkg::VIT_OFF ##1
    state_reg == vit_pkg::VIT_IDLE);
  c_accept: cover property (@(posedge clk) disable iff (rst) $rose(accepted_reg));
endmodule : vit_arbiter

// file: bench/vit_partner.sv
// Bus arbiter model that grants the tenure block the bus
`timescale 1ns/1ps
module vit_partner (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Arbitration
  input wire logic slow,
  input wire logic bus_req,
  input wire logic bus_busy,
  output logic bus_grant
);
  // ****************************************
  // Grant logic
  // ****************************************
  logic [2:0] dly_reg;
  // Grant stands until both request and busy are gone, so a stale grant is never reused
  always_ff @(posedge clk) begin
    if (rst) begin
      bus_grant <= 1'b0;
      dly_reg <= 3'h0;
    end else if (bus_grant) begin
      if (!bus_req && !bus_busy) bus_grant <= 1'b0;
    end else if (bus_req) begin
      dly_reg <= dly_reg + 3'h1;
      if (!slow || dly_reg == 3'h5) begin
        bus_grant <= 1'b1;
        dly_reg <= 3'h0;
      end
    end
  end
endmodule : vit_partner

// file: bench/testbench.sv
// Self-checking bench for the init checker and bus tenure arbiter
`timescale 1ns/1ps
`include "vit_map.svh"
module testbench;
  // ****************************************
  // Signals and helpers
  // ****************************************
  localparam int B = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic bus_req_line = 1'b0;
  logic done_ok = 1'b0;
  logic done_err = 1'b0;
  logic slow = 1'b0;
  logic hreadyout, hresp, bus_grant, bus_req, bus_busy, init_accepted, err_recorded;
  logic [31:0] hrdata, block_offset, q, ba;
  vit_pkg::vit_irq_s irq_out;
  int seed = 32'h3444;
  int mismatches = 0;
  int comparisons = 0;
  int cnt, g, lo;
  logic [16:0] tbl[$];
  logic [2:0] nl, el;
  logic [7:0] nv, ev;
  always #4 clk = ~clk;
  vit_arbiter #(.BASE_CYC(B)) vit_arbiter_i (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .bus_grant(bus_grant),
    .bus_req_line(bus_req_line), .bus_req(bus_req), .bus_busy(bus_busy), .done_ok(done_ok),
    .done_err(done_err), .init_accepted(init_accepted), .block_offset(block_offset),
    .irq_out(irq_out), .err_recorded(err_recorded));
  vit_partner vit_partner_i (.clk(clk), .rst(rst), .slow(slow), .bus_req(bus_req),
    .bus_busy(bus_busy), .bus_grant(bus_grant));
  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tmo;
    mismatches++;
    $display("MISMATCH at %0t: wait ran out", $time);
    close_out();
  endtask : tmo
  // One single word transfer; read data lands in q
  task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    int k;
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    for (n = 0; n < 2; n++) begin
      k = 0;
      do begin
        @(posedge clk);
        k++;
      end while (hreadyout !== 1'b1 && k < 20);
      if (k >= 20) tmo();
      if (n == 0) begin
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
      end
    end
    q = hrdata;
  endtask : ahb
  task automatic wait_sig(input bit s, input logic v);
    int k;
    for (k = 0; (s ? bus_req : bus_busy) !== v; k++) begin
      if (k == 400) tmo();
      @(negedge clk);
    end
  endtask : wait_sig
  task automatic pulse(input logic [1:0] d);
    @(posedge clk);
    {done_err, done_ok} <= d;
    @(posedge clk);
    {done_err, done_ok} <= 2'b00;
    @(negedge clk);
  endtask : pulse
  // Busy cycles expected; 300 stands for holding until pending drops
  function automatic int exp_ten(input logic [15:0] w, input logic ln);
    if (w[15]) return (w[2:0] == 3'h7) ? 300 : (B << w[2:0]);
    if (w[7:0] == 8'h00) return 300;
    if (w[7:0] <= 8'h20 && ln) return 1;
    if (w[7:0] <= 8'h40) return B;
    if (w[7:0] <= 8'h80) return 2 * B;
    return 4 * B;
  endfunction : exp_ten
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    tbl = '{17'h00000, 17'h10001, 17'h00020, 17'h10021, 17'h00040, 17'h00041,
      17'h00080, 17'h00081, 17'h000ff, 17'h18002, 17'h1c001};
    for (int t = 0; t < 8; t++) tbl.push_back({3'b010, 7'h00, 3'(7 - t), 1'b0, 3'(t)});
    repeat (4) tbl.push_back({1'($random(seed)), 8'h00, 8'($random(seed))});
    foreach (tbl[i]) begin
      @(posedge clk);
      slow <= (i % 2) == 1;
      rst <= 1'b1;
      bus_req_line <= 1'b0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      check({hreadyout, hresp, bus_req, bus_busy, init_accepted}, 5'b10000);
      ba = $random(seed);
      {nl, nv, el, ev} = 22'($random(seed));
      if (i == 0) el = 3'h0;
      ahb(1'b1, `VIT_OFS_XFER, 32'h0000_0300);
      ahb(1'b1, `VIT_OFS_BUFADDR, ba);
      ahb(1'b1, `VIT_OFS_SLOTS, 32'h1 + 32'($random(seed) & 15));
      ahb(1'b1, `VIT_OFS_BURST, {16'h0, tbl[i][15:0]});
      ahb(1'b1, `VIT_OFS_NORM, {21'h0, nl, nv});
      ahb(1'b1, `VIT_OFS_ERR, {21'h0, el, ev});
      if (i == 0) begin
        for (int m = 0; m < 4; m++) begin
          ahb(1'b1, `VIT_OFS_XFER, m < 3 ? 32'(m) << 8 : 32'h300);
          ahb(1'b1, `VIT_OFS_MAXLEN, m < 3 ? `VIT_BLOCK_BYTES : 32'h2c);
          ahb(1'b1, `VIT_OFS_CTRL, 32'h1);
          ahb(1'b0, `VIT_OFS_STATUS, 32'h0);
          check(q[1:0], 2'b10);
        end
        ahb(1'b0, 12'h0fc, 32'h0);
        check(q, 32'h0);
      end
      ahb(1'b1, `VIT_OFS_MAXLEN, `VIT_BLOCK_BYTES);
      ahb(1'b1, `VIT_OFS_CTRL, 32'h1);
      ahb(1'b0, `VIT_OFS_STATUS, 32'h0);
      check(q[7:0], 8'h11);
      check({init_accepted, block_offset}, {1'b1, ba});
      ahb(1'b0, `VIT_OFS_BURST, 32'h0);
      check(q, {16'h0, tbl[i][15:0]});
      pulse(2'b01);
      check({irq_out, err_recorded}, {1'b1, nl, nv, 1'b0});
      ahb(1'b0, `VIT_OFS_EVENT, 32'h0);
      check(q[1:0], 2'b01);
      ahb(1'b0, `VIT_OFS_NORM, 32'h0);
      check(q, {21'h0, nl, nv});
      ahb(1'b1, `VIT_OFS_EVENT, 32'h3);
      ahb(1'b0, `VIT_OFS_EVENT, 32'h0);
      check(q[1:0], 2'b00);
      pulse(2'b10);
      check({irq_out.req, err_recorded}, {el != 3'h0, 1'b1});
      if (el != 3'h0) check(irq_out, {1'b1, el, ev});
      @(posedge clk);
      bus_req_line <= tbl[i][16];
      ahb(1'b1, `VIT_OFS_CTRL, 32'h2);
      if (tbl[i][15:14] == 2'b11) begin
        repeat (20) @(negedge clk);
        check(bus_req, 1'b0);
        @(posedge clk);
        bus_req_line <= 1'b0;
      end
      wait_sig(1'b0, 1'b1);
      for (cnt = 0; bus_busy === 1'b1 && cnt < 300; cnt++) @(negedge clk);
      check(cnt, exp_ten(tbl[i][15:0], tbl[i][16]));
      if (tbl[i][15] && cnt < 300) begin
        for (g = 0; bus_req !== 1'b1 && g < 400; g++) @(negedge clk);
        lo = tbl[i][6:4] == 3'h0 ? 0 : B << (tbl[i][6:4] - 3'h1);
        check(g >= lo && g <= lo + 3, 1'b1);
      end
      if (cnt == 300) begin
        ahb(1'b0, `VIT_OFS_STATUS, 32'h0);
        check(q[7:0], 8'h49);
      end
      ahb(1'b0, `VIT_OFS_CTRL, 32'h0);
      check(q[1], 1'b1);
      // Pending drops only here, so a hold that never ends shows up as a busy count of 300
      ahb(1'b1, `VIT_OFS_CTRL, 32'h0);
      wait_sig(1'b0, 1'b0);
    end
    close_out();
  end
endmodule : testbench
